/* File: design/fsmo_pkg.sv */
// Package for the frame sync monitor block: register map, field layout,
// timing constants, used by both design files, and the signal bundles of the top design file.
// Assumes a 20 MHz master clock and an AXI4-Lite register bus.
package fsmo_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int unsigned CLK_PERIOD_NS = 50;
  // Crystal frame clock period at normal speed
  localparam int unsigned FRAME_CLK_NS = 136000;
  localparam int unsigned FRAME_CLK_CYC = FRAME_CLK_NS / CLK_PERIOD_NS;
  // Lock sampling rate
  localparam int unsigned LOCK_SAMPLE_HZ = 460;
  localparam int unsigned CLK_HZ = 1000000000 / CLK_PERIOD_NS;
  localparam int unsigned LOCK_SAMPLE_CYC = CLK_HZ / LOCK_SAMPLE_HZ;
  localparam int unsigned LOCK_MISS_LIMIT = 8;
  // Recovered bit clock period in master clocks
  localparam int unsigned BIT_CLK_CYC = 4;
  // Jitter buffer margin in frames
  localparam int unsigned BUF_MARGIN = 28;
  localparam int unsigned BUF_OFS_W = 8;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam int unsigned AXI_ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_INT_STAT = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK = 8'h0c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control: monitor select in the two low bits
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int unsigned SEL_W = 2;
  localparam int unsigned INT_W = 4;
  localparam logic [3:0] INT_MASK_RESET = 4'h0;
  // Interrupt event bit positions
  localparam int unsigned EV_OVERFLOW = 0;
  localparam int unsigned EV_LOCK_LOST = 1;
  localparam int unsigned EV_LOCK_GAINED = 2;
  localparam int unsigned EV_SYNC_MISSED = 3;

  // Monitor select codes
  typedef enum logic [1:0] {
    FSMO_SEL_SYNC = 2'h0,
    FSMO_SEL_INTERNAL = 2'h1,
    FSMO_SEL_CLOCK = 2'h2,
    FSMO_SEL_NONE = 2'h3
  } fsmo_sel_t;

  // ==========================================================
  // Bundles
  // ==========================================================
  // Status from the decoder core, same clock domain
  typedef struct packed {
    logic sync_det;
    logic sync_expect;
    logic win_released;
    logic c2_err;
    logic signed [BUF_OFS_W-1:0] buf_offset;
    logic [3:0] internal_monitor;
  } fsmo_dec_t;

  // Monitor flag set, one bit per signal
  typedef struct packed {
    logic raw_frame_sync_pulse_n;
    logic inverted_bit_clock_monitor;
    logic frame_sync_good_flag;
    logic sync_window_released_flag;
    logic crystal_frame_clock;
    logic second_stage_error_flag;
    logic jitter_buffer_overflow_flag;
  } fsmo_flags_t;

endpackage

/* File: design/fsmo_lock_det.sv */
// Lock indicator: samples the sync good flag on a slow enable.
// Assumes good_i is on the same clock; reset is synchronous, active high.
`timescale 1ns/100ps
module fsmo_lock_det #(
  parameter int unsigned SAMPLE_CYCLES = fsmo_pkg::LOCK_SAMPLE_CYC,
  parameter int unsigned MISS_LIMIT = fsmo_pkg::LOCK_MISS_LIMIT
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Flag in, lock out
  input wire logic good_i,
  output logic lock_o
);

  localparam int unsigned DIV_W = $clog2(SAMPLE_CYCLES);
  localparam int unsigned MISS_W = $clog2(MISS_LIMIT + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SAMPLE_CYCLES - 1);
  localparam logic [MISS_W-1:0] MISS_LAST = MISS_W'(MISS_LIMIT - 1);

  logic [DIV_W-1:0] div_reg;
  logic [MISS_W-1:0] miss_reg;
  logic sample_en;

  assign sample_en = (div_reg == DIV_LAST);

  // ==========================================================
  // Sample rate divider
  // ==========================================================
  always_ff @(posedge clk_i) begin
    if (rst_i || sample_en) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // ==========================================================
  // Lock decision
  // ==========================================================
  // [R10] high on sample, low after eight
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      miss_reg <= '0;
      lock_o <= 1'b0;
    end else if (sample_en) begin
      if (good_i) begin
        miss_reg <= '0;
        lock_o <= 1'b1;
      end else if (miss_reg == MISS_LAST) begin
        lock_o <= 1'b0;
      end else begin
        miss_reg <= miss_reg + 1'b1;
      end
    end
  end

endmodule // fsmo_lock_det

/* File: design/fsmo_top.sv */
// Frame sync monitor outputs: flag generation, monitor pin routing,
// lock indicator and an AXI4-Lite register slave with interrupt.
// Assumes decoder status arrives on CLOCK_I; EFM input is asynchronous.
`timescale 1ns/100ps

// Operation
// [R1] Raw frame sync as low pulse
// [R2] Clock monitor is inverted bit clock
// [R3] Bit clock falls on EFM transitions
// [R4] Sync good when sync meets expected timing
// [R5] Flag high while protection window released
// [R6] Crystal frame clock, 136 us period
// [R7] Overflow when buffer exceeds 28 frames
// [R8] Flag shows second-stage error status
// [R9] Two-bit select routes four monitor pins
// [R10] Lock from sync good sampled 460 Hz
// [R11] Flags synchronous, inactive during reset; MONITOR_O is 0 in reset, so the raw sync pin shows its active low level
module fsmo_top #(
  parameter int unsigned SAMPLE_CYCLES = fsmo_pkg::LOCK_SAMPLE_CYC,
  parameter int unsigned FRAME_CYCLES = fsmo_pkg::FRAME_CLK_CYC,
  parameter int unsigned BIT_CYCLES = fsmo_pkg::BIT_CLK_CYC,
  parameter int unsigned MARGIN = fsmo_pkg::BUF_MARGIN
) (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  // Decoder core status
  input wire fsmo_pkg::fsmo_dec_t DEC_I,
  input wire logic EFM_I,
  // Monitor pins, lock and interrupt
  output logic [3:0] MONITOR_O,
  output logic LOCK_O,
  output logic IRQ_O,
  // AXI4-Lite write address and data
  input wire logic [fsmo_pkg::AXI_ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // AXI4-Lite read
  input wire logic [fsmo_pkg::AXI_ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I
);

  localparam int unsigned BIT_W = $clog2(BIT_CYCLES);
  localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(BIT_CYCLES - 1);
  localparam logic [BIT_W-1:0] BIT_HALF = BIT_W'(BIT_CYCLES / 2);
  localparam int unsigned FRM_W = $clog2(FRAME_CYCLES);
  localparam logic [FRM_W-1:0] FRM_HALF_LAST =
    FRM_W'(FRAME_CYCLES / 2 - 1);
  localparam int unsigned OFS_W = fsmo_pkg::BUF_OFS_W;
  localparam logic signed [OFS_W-1:0] OFS_HI = OFS_W'(MARGIN);
  localparam logic signed [OFS_W-1:0] OFS_LO = -OFS_HI;
  localparam int unsigned SEL_W = fsmo_pkg::SEL_W;
  localparam int unsigned INT_W = fsmo_pkg::INT_W;

  fsmo_pkg::fsmo_flags_t flags_reg;
  logic efm_meta_reg;
  logic efm_sync_reg;
  logic efm_prev_reg;
  logic efm_edge;
  logic [BIT_W-1:0] bit_phase_reg;
  logic bit_clk_reg;
  logic [FRM_W-1:0] frm_cnt_reg;
  logic over_now;
  logic over_rise;
  logic sync_missed;
  logic lock;
  logic lock_prev_reg;
  logic [SEL_W-1:0] sel_reg;
  logic [INT_W-1:0] int_stat_reg;
  logic [INT_W-1:0] int_mask_reg;
  logic [INT_W-1:0] int_event;
  logic [INT_W-1:0] int_clear;

  // ==========================================================
  // EFM input synchroniser
  // ==========================================================
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      efm_meta_reg <= 1'b0;
      efm_sync_reg <= 1'b0;
      efm_prev_reg <= 1'b0;
    end else begin
      efm_meta_reg <= EFM_I;
      efm_sync_reg <= efm_meta_reg;
      efm_prev_reg <= efm_sync_reg;
    end
  end

  assign efm_edge = efm_sync_reg ^ efm_prev_reg;

  // ==========================================================
  // Recovered bit clock
  // ==========================================================
  // [R3] falling edge aligned to transition
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      bit_phase_reg <= '0;
    end else if (efm_edge) begin
      bit_phase_reg <= BIT_HALF;
    end else if (bit_phase_reg == BIT_LAST) begin
      bit_phase_reg <= '0;
    end else begin
      bit_phase_reg <= bit_phase_reg + 1'b1;
    end
  end

  // High in the first half, falls at the half point
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      bit_clk_reg <= 1'b1;
    end else if (efm_edge) begin
      bit_clk_reg <= 1'b0;
    end else if (bit_phase_reg == BIT_LAST) begin
      bit_clk_reg <= 1'b1;
    end else if (bit_phase_reg == BIT_HALF - 1'b1) begin
      bit_clk_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Crystal frame clock
  // ==========================================================
  // [R6] free divider from master clock
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      frm_cnt_reg <= '0;
    end else if (frm_cnt_reg == FRM_HALF_LAST) begin
      frm_cnt_reg <= '0;
    end else begin
      frm_cnt_reg <= frm_cnt_reg + 1'b1;
    end
  end

  // ==========================================================
  // Monitor flags
  // ==========================================================
  assign over_now = (DEC_I.buf_offset > OFS_HI) ||
                    (DEC_I.buf_offset < OFS_LO);
  assign sync_missed = DEC_I.sync_expect && !DEC_I.sync_det;
  assign over_rise = over_now && !flags_reg.jitter_buffer_overflow_flag;

  // [R11] reset holds inactive levels
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      flags_reg.raw_frame_sync_pulse_n <= 1'b1;
      flags_reg.inverted_bit_clock_monitor <= 1'b0;
      flags_reg.frame_sync_good_flag <= 1'b0;
      flags_reg.sync_window_released_flag <= 1'b0;
      flags_reg.crystal_frame_clock <= 1'b0;
      flags_reg.second_stage_error_flag <= 1'b0;
      flags_reg.jitter_buffer_overflow_flag <= 1'b0;
    end else begin
      // [R1] unprotected sync, active low
      flags_reg.raw_frame_sync_pulse_n <= ~DEC_I.sync_det;
      // [R2] inverse of bit clock
      flags_reg.inverted_bit_clock_monitor <= ~bit_clk_reg;
      // [R5] window released level
      flags_reg.sync_window_released_flag <= DEC_I.win_released;
      // [R8] second-stage error status
      flags_reg.second_stage_error_flag <= DEC_I.c2_err;
      // [R7] beyond plus or minus margin
      flags_reg.jitter_buffer_overflow_flag <= over_now;
      if (frm_cnt_reg == FRM_HALF_LAST) begin
        flags_reg.crystal_frame_clock <=
          ~flags_reg.crystal_frame_clock;
      end
      // [R4] sync at expected slot
      if (DEC_I.sync_expect) begin
        flags_reg.frame_sync_good_flag <= DEC_I.sync_det;
      end
    end
  end

  // ==========================================================
  // Lock indicator
  // ==========================================================
  // [R10] sampled sync good flag
  fsmo_lock_det #(
    .SAMPLE_CYCLES(SAMPLE_CYCLES),
    .MISS_LIMIT(fsmo_pkg::LOCK_MISS_LIMIT)
  ) u_lock (
    .clk_i(CLOCK_I),
    .rst_i(SYS_RST_I),
    .good_i(flags_reg.frame_sync_good_flag),
    .lock_o(lock)
  );

  assign LOCK_O = lock;

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      lock_prev_reg <= 1'b0;
    end else begin
      lock_prev_reg <= lock;
    end
  end

  // ==========================================================
  // Monitor pin routing
  // ==========================================================
  // [R9] select chooses the pin set
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      MONITOR_O <= 4'h0;
    end else begin
      unique case (fsmo_pkg::fsmo_sel_t'(sel_reg))
        fsmo_pkg::FSMO_SEL_SYNC: begin
          MONITOR_O <= {flags_reg.second_stage_error_flag,
                        flags_reg.frame_sync_good_flag,
                        flags_reg.inverted_bit_clock_monitor,
                        flags_reg.raw_frame_sync_pulse_n};
        end
        fsmo_pkg::FSMO_SEL_INTERNAL: begin
          MONITOR_O <= DEC_I.internal_monitor;
        end
        fsmo_pkg::FSMO_SEL_CLOCK: begin
          MONITOR_O <= {flags_reg.sync_window_released_flag,
                        flags_reg.jitter_buffer_overflow_flag,
                        flags_reg.inverted_bit_clock_monitor,
                        flags_reg.crystal_frame_clock};
        end
        fsmo_pkg::FSMO_SEL_NONE: begin
          MONITOR_O <= 4'h0;
        end
      endcase
    end
  end

  // ==========================================================
  // AXI4-Lite write channel
  // ==========================================================
  logic aw_held_reg;
  logic w_held_reg;
  logic [fsmo_pkg::AXI_ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_do;
  logic wr_lo;

  assign S_AXI_AWREADY_O = !aw_held_reg && !S_AXI_BVALID_O;
  assign S_AXI_WREADY_O = !w_held_reg && !S_AXI_BVALID_O;
  assign wr_do = aw_held_reg && w_held_reg && !S_AXI_BVALID_O;
  assign wr_lo = wr_do && wstrb_reg[0];

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= '0;
    end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= S_AXI_AWADDR_I;
    end else if (wr_do) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      w_held_reg <= 1'b1;
      wdata_reg <= S_AXI_WDATA_I;
      wstrb_reg <= S_AXI_WSTRB_I;
    end else if (wr_do) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= fsmo_pkg::RESP_OKAY;
    end else if (wr_do) begin
      S_AXI_BVALID_O <= 1'b1;
      unique case (awaddr_reg)
        fsmo_pkg::ADDR_CTRL, fsmo_pkg::ADDR_STATUS,
        fsmo_pkg::ADDR_INT_STAT, fsmo_pkg::ADDR_INT_MASK: begin
          S_AXI_BRESP_O <= fsmo_pkg::RESP_OKAY;
        end
        default: begin
          S_AXI_BRESP_O <= fsmo_pkg::RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_BREADY_I) begin
      S_AXI_BVALID_O <= 1'b0;
    end
  end

  // ==========================================================
  // Control and interrupt registers
  // ==========================================================
  // [R9] software monitor select
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      sel_reg <= fsmo_pkg::CTRL_RESET;
    end else if (wr_lo && awaddr_reg == fsmo_pkg::ADDR_CTRL) begin
      sel_reg <= wdata_reg[SEL_W-1:0];
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      int_mask_reg <= fsmo_pkg::INT_MASK_RESET;
    end else if (wr_lo && awaddr_reg == fsmo_pkg::ADDR_INT_MASK) begin
      int_mask_reg <= wdata_reg[INT_W-1:0];
    end
  end

  always_comb begin
    int_event = '0;
    int_event[fsmo_pkg::EV_OVERFLOW] = over_rise;
    int_event[fsmo_pkg::EV_LOCK_LOST] = lock_prev_reg && !lock;
    int_event[fsmo_pkg::EV_LOCK_GAINED] = !lock_prev_reg && lock;
    int_event[fsmo_pkg::EV_SYNC_MISSED] = sync_missed;
  end

  assign int_clear = (wr_lo && awaddr_reg == fsmo_pkg::ADDR_INT_STAT) ?
                     wdata_reg[INT_W-1:0] : '0;

  // Set wins over a write-one clear
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      int_stat_reg <= '0;
    end else begin
      int_stat_reg <= (int_stat_reg & ~int_clear) | int_event;
    end
  end

  assign IRQ_O = |(int_stat_reg & int_mask_reg);

  // ==========================================================
  // AXI4-Lite read channel
  // ==========================================================
  logic [31:0] status_word;

  always_comb begin
    status_word = 32'h0;
    status_word[0] = flags_reg.raw_frame_sync_pulse_n;
    status_word[1] = flags_reg.inverted_bit_clock_monitor;
    status_word[2] = flags_reg.frame_sync_good_flag;
    status_word[3] = flags_reg.sync_window_released_flag;
    status_word[4] = flags_reg.crystal_frame_clock;
    status_word[5] = flags_reg.second_stage_error_flag;
    status_word[6] = flags_reg.jitter_buffer_overflow_flag;
    status_word[7] = lock;
  end

  assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h0;
      S_AXI_RRESP_O <= fsmo_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RRESP_O <= fsmo_pkg::RESP_OKAY;
      unique case (S_AXI_ARADDR_I)
        fsmo_pkg::ADDR_CTRL: begin
          S_AXI_RDATA_O <= {{(32-SEL_W){1'b0}}, sel_reg};
        end
        fsmo_pkg::ADDR_STATUS: begin
          S_AXI_RDATA_O <= status_word;
        end
        fsmo_pkg::ADDR_INT_STAT: begin
          S_AXI_RDATA_O <= {{(32-INT_W){1'b0}}, int_stat_reg};
        end
        fsmo_pkg::ADDR_INT_MASK: begin
          S_AXI_RDATA_O <= {{(32-INT_W){1'b0}}, int_mask_reg};
        end
        default: begin
          S_AXI_RDATA_O <= 32'h0;
          S_AXI_RRESP_O <= fsmo_pkg::RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end

endmodule // fsmo_top

/* File: sim/fsmo_assertions.sv */
// Checker for the monitor pins, bound into the top module.
// Assumes AW and W of a control write are taken at the same edge.
`timescale 1ns/100ps
module fsmo_assertions #(
  parameter int FRAME_CYCLES = fsmo_pkg::FRAME_CLK_CYC,
  parameter int MARGIN = fsmo_pkg::BUF_MARGIN
) (
  // Clock, reset, decoder side
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  input wire fsmo_pkg::fsmo_dec_t DEC_I,
  input wire logic EFM_I,
  // Pins
  input wire logic [3:0] MONITOR_O,
  input wire logic LOCK_O,
  input wire logic IRQ_O,
  // Write channels
  input wire logic [fsmo_pkg::AXI_ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O
);
  // ==========================================================
  // Select tracking
  // ==========================================================
  localparam int HALF = FRAME_CYCLES / 2 - 1;
  logic [1:0] sel_q;
  logic [3:0] quiet_q;
  logic [3:0] efm_q;
  logic [15:0] fc_q;
  logic take, stab, s0, s2, sb, ovf;
  assign take = S_AXI_AWVALID_I && S_AXI_AWREADY_O
    && S_AXI_WVALID_I && S_AXI_WREADY_O;
  assign stab = quiet_q == 4'hf;
  assign s0 = stab && sel_q == 2'h0;
  assign s2 = stab && sel_q == 2'h2;
  assign sb = stab && !sel_q[0];
  assign ovf = $signed(DEC_I.buf_offset) > MARGIN
    || $signed(DEC_I.buf_offset) < -MARGIN;
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) sel_q <= 2'h0;
    else if (take && S_AXI_AWADDR_I == fsmo_pkg::ADDR_CTRL
      && S_AXI_WSTRB_I[0]) sel_q <= S_AXI_WDATA_I[1:0];
  end
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I || take) quiet_q <= 4'h0;
    else if (!stab) quiet_q <= quiet_q + 4'h1;
  end
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I || $changed(EFM_I)) efm_q <= 4'h0;
    else if (efm_q != 4'hf) efm_q <= efm_q + 4'h1;
  end
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I || $changed(MONITOR_O[0])) fc_q <= 16'h0;
    else fc_q <= fc_q + 16'h1;
  end
  // ==========================================================
  // Properties
  // ==========================================================
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);
  sequence bit_rise_s;
    $rose(MONITOR_O[1]);
  endsequence
  reset_quiet_a: assert property (disable iff (1'b0)
    SYS_RST_I |=> MONITOR_O == 4'h0 && !LOCK_O && !IRQ_O)
    else $error("outputs active in reset");
  raw_sync_a: assert property (s0 |-> ##2
    MONITOR_O[0] != $past(DEC_I.sync_det, 2))
    else $error("raw sync pin wrong");
  sync_good_a: assert property (s0 && DEC_I.sync_expect |-> ##2
    MONITOR_O[2] == $past(DEC_I.sync_det, 2))
    else $error("sync good pin wrong");
  c2_flag_a: assert property (s0 |-> ##2
    MONITOR_O[3] == $past(DEC_I.c2_err, 2))
    else $error("error flag pin wrong");
  overflow_flag_a: assert property (s2 |-> ##2
    MONITOR_O[2] == $past(ovf, 2))
    else $error("overflow pin wrong");
  window_flag_a: assert property (s2 |-> ##2
    MONITOR_O[3] == $past(DEC_I.win_released, 2))
    else $error("window pin wrong");
  frame_half_a: assert property (
    s2 && $changed(MONITOR_O[0]) |-> fc_q == HALF)
    else $error("frame clock half period wrong");
  bit_period_a: assert property (
    sb && efm_q == 4'hf ##0 bit_rise_s |->
    ##4 ($rose(MONITOR_O[1]) || efm_q < 4'h6))
    else $error("bit clock period wrong");
endmodule // fsmo_assertions

bind fsmo_top fsmo_assertions #(.FRAME_CYCLES(FRAME_CYCLES),
  .MARGIN(MARGIN)) i_chk (.*);

/* File: sim/fsmo_pin_watch.sv */
// Observer on the monitor pins: measures the clocks seen on them.
// Assumes pins are sampled on the master clock.
`timescale 1ns/100ps
module fsmo_pin_watch (
  // Clock
  input wire logic clk_i,
  // Pins observed
  input wire logic [3:0] mon_i,
  // Measured spans in cycles
  output logic [15:0] half_o,
  output logic [15:0] per_o
);
  logic [3:0] last;
  logic [15:0] a, b;
  always_ff @(posedge clk_i) begin
    last <= mon_i;
    a <= (mon_i[0] != last[0]) ? 16'h1 : a + 16'h1;
    b <= (mon_i[1] && !last[1]) ? 16'h1 : b + 16'h1;
    if (mon_i[0] != last[0]) half_o <= a;
    if (mon_i[1] && !last[1]) per_o <= b;
  end
endmodule // fsmo_pin_watch

/* File: sim/fsmo_top_tb.sv */
// Self-checking bench: random decoder status, AXI4-Lite register tasks.
// Assumes the pin watcher and the bound checker are compiled with it.
`timescale 1ns/100ps
module fsmo_top_tb;
  // ==========================================================
  // Setup
  // ==========================================================
  localparam int SC = 16;
  localparam int FC = 8;
  localparam int BC = 4;
  logic clk, rst, efm, lock, irq;
  fsmo_pkg::fsmo_dec_t dec;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, r;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [3:0] mon;
  logic [15:0] half, per;
  logic signed [7:0] v;
  logic signed [7:0] ofs [7] = '{8'sh1c, 8'sh1d, 8'she4, 8'she3,
    8'sh7f, 8'sh80, 8'sh00};
  int n_errors, compares, seed, i;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  fsmo_top #(.SAMPLE_CYCLES(SC), .FRAME_CYCLES(FC),
    .BIT_CYCLES(BC), .MARGIN(28)) i_dut (
    .CLOCK_I(clk), .SYS_RST_I(rst), .DEC_I(dec), .EFM_I(efm),
    .MONITOR_O(mon), .LOCK_O(lock), .IRQ_O(irq),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready));
  fsmo_pin_watch i_watch (.clk_i(clk), .mon_i(mon), .half_o(half),
    .per_o(per));
  // ==========================================================
  // Tasks
  // ==========================================================
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, ha, hw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge clk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      @(posedge clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      ta = ta || ha;
      tw = tw || hw;
    end
    do @(negedge clk); while (bvalid !== 1'b1);
    rsp = bresp;
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a);
    logic h;
    h = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!h) begin
      @(negedge clk);
      h = arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    r = rdata;
    rsp = rresp;
    @(posedge clk);
  endtask
  task settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  function logic ovf_exp(input logic signed [7:0] x);
    return (x > 8'sh1c) || (x < 8'she4);
  endfunction
  // ==========================================================
  // Sequence
  // ==========================================================
  initial begin
    #250000;
    n_errors++;
    final_report;
  end
  initial begin
    seed = 32'h7aab;
    n_errors = 0;
    compares = 0;
    rst = 1'b1;
    efm = 1'b0;
    dec = '0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (7) @(posedge clk);
    @(negedge clk);
    chk({lock, irq, mon}, 32'h0);
    @(posedge clk);
    rst <= 1'b0;
    bready <= 1'b1;
    rready <= 1'b1;
    rd(fsmo_pkg::ADDR_CTRL);
    chk(r, 32'h0);
    rd(8'h10);
    chk(rsp, fsmo_pkg::RESP_SLVERR);
    chk(r, 32'h0);
    for (i = 0; i < 24; i++) begin
      @(posedge clk);
      dec.sync_det <= 1'($random(seed));
      dec.sync_expect <= (i == 0) ? 1'b1 : 1'($random(seed));
      dec.c2_err <= 1'($random(seed));
      settle;
      chk(mon[0], !dec.sync_det);
      chk(mon[3], dec.c2_err);
      if (dec.sync_expect) chk(mon[2], dec.sync_det);
    end
    @(posedge clk);
    dec.sync_expect <= 1'b1;
    dec.sync_det <= 1'b1;
    @(posedge clk);
    dec.sync_expect <= 1'b0;
    dec.sync_det <= 1'b0;
    settle;
    chk(mon[2], 1'b1);
    repeat (3 * SC) @(posedge clk);
    chk(lock, 1'b1);
    @(posedge clk);
    dec.sync_expect <= 1'b1;
    @(posedge clk);
    dec.sync_expect <= 1'b0;
    repeat (7 * SC - 4) @(posedge clk);
    chk(lock, 1'b1);
    repeat (SC + 12) @(posedge clk);
    chk(lock, 1'b0);
    wr(fsmo_pkg::ADDR_CTRL, 32'h1);
    chk(rsp, fsmo_pkg::RESP_OKAY);
    for (i = 0; i < 6; i++) begin
      @(posedge clk);
      dec.internal_monitor <= 4'($random(seed));
      settle;
      chk(mon, dec.internal_monitor);
    end
    wr(fsmo_pkg::ADDR_INT_MASK, 32'h1);
    wr(fsmo_pkg::ADDR_CTRL, 32'h2);
    for (i = 0; i < 12; i++) begin
      v = (i < 7) ? ofs[i] : 8'($random(seed));
      @(posedge clk);
      dec.buf_offset <= (i == 11) ? 8'sh00 : v;
      dec.win_released <= 1'($random(seed));
      settle;
      chk(mon[2], ovf_exp(dec.buf_offset));
      chk(mon[3], dec.win_released);
    end
    chk(half, FC / 2);
    chk(per, BC);
    chk(irq, 1'b1);
    rd(fsmo_pkg::ADDR_INT_STAT);
    chk(r, 32'hf);
    wr(fsmo_pkg::ADDR_INT_STAT, 32'h1);
    @(negedge clk);
    chk(irq, 1'b0);
    wr(fsmo_pkg::ADDR_INT_MASK, 32'h0);
    dec.buf_offset <= 8'sh7f;
    settle;
    chk(irq, 1'b0);
    rd(fsmo_pkg::ADDR_INT_STAT);
    chk(r, 32'hf);
    rd(fsmo_pkg::ADDR_STATUS);
    chk(r[7:6], 2'h1);
    wr(fsmo_pkg::ADDR_CTRL, 32'h3);
    settle;
    chk(mon, 4'h0);
    wr(fsmo_pkg::ADDR_CTRL, 32'h0);
    for (i = 0; i < 3; i++) begin
      do @(negedge clk); while (mon[1] !== 1'b0);
      do @(negedge clk); while (mon[1] !== 1'b1);
      @(posedge clk);
      efm <= ~efm;
      repeat (5) @(posedge clk);
      @(negedge clk);
      chk(mon[1], 1'b1);
    end
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({lock, irq, mon}, 32'h0);
    final_report;
  end
endmodule // fsmo_top_tb
